// File: cms_pkg.sv
// cms_pkg.sv - constants shared by the controller end and the node end
// assumes: both ends are compiled after this package
package cms_pkg;

	// ******************************
	// register map of the controller
	// ******************************
	localparam logic [4:0] ADDR_CTRL1 = 5'h00;
	localparam logic [4:0] ADDR_CFG_A = 5'h01;
	localparam logic [4:0] ADDR_CFG_B = 5'h02;
	localparam logic [4:0] ADDR_STATUS = 5'h03;
	localparam logic [4:0] ADDR_PAIR0 = 5'h04;
	localparam logic [4:0] ADDR_ID0 = 5'h08;
	localparam logic [4:0] ADDR_DATA0 = 5'h10;
	localparam logic [4:0] ADDR_RX_ID = 5'h18;
	localparam logic [4:0] ADDR_RX_DATA = 5'h19;

	// ******************************
	// field positions
	// ******************************
	localparam int CTRL_ABORT = 12;
	localparam int REQ_LO = 8;
	localparam int STAT_LO = 5;
	localparam int BUF_TXSEL = 7;
	localparam int BUF_TXREQ = 3;
	localparam int BUF_PRI_LO = 0;
	localparam int STS_RX_VALID = 0;
	localparam int STS_RX_ERR = 1;
	localparam int STS_TX_ACTIVE = 2;
	localparam int STS_LOST = 3;

	// ******************************
	// operating modes
	// ******************************
	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_DISABLE = 3'h1;
	localparam logic [2:0] MODE_LOOPBACK = 3'h2;
	localparam logic [2:0] MODE_LISTEN_ONLY = 3'h3;
	localparam logic [2:0] MODE_CONFIG = 3'h4;
	localparam logic [2:0] MODE_LISTEN_ALL = 3'h7;

	// ******************************
	// reset values and sizes
	// ******************************
	localparam int NBUF = 8;
	localparam int ID_W = 11;
	localparam int DATA_W = 8;
	localparam logic [7:0] CFG_A_RST = 8'h03;
	localparam logic [7:0] CFG_B_RST = 8'h03;

	// ******************************
	// frame timing in bits
	// ******************************
	localparam logic [3:0] IDLE_BITS = 4'hb;
	localparam logic [3:0] IFS_BITS = 4'h3;
	localparam logic [4:0] POS_ID_FIRST = 5'h01;
	localparam logic [4:0] POS_ID_LAST = 5'h0b;
	localparam logic [4:0] POS_DATA_LAST = 5'h13;
	localparam logic [4:0] POS_ACK = 5'h14;
	localparam logic [4:0] POS_EOF_FIRST = 5'h15;
	localparam logic [4:0] POS_LAST = 5'h1b;
	localparam logic [6:0] EOF_FIELD = 7'h7f;

	// frame engine states, gray along idle, tx, rx
	typedef enum logic [1:0] {
		FR_IDLE = 2'b00,
		FR_TX = 2'b01,
		FR_RX = 2'b11
	} cms_frame_type;

endpackage

// File: cms_link_if.sv
// cms_link_if.sv - shared wired-and bus between the controller and a node
// assumes: low is dominant, each end drives its own transmit bit
`timescale 1ns/10ps
`default_nettype none
interface cms_link_if;
	logic dev_tx;
	logic node_tx;
	logic bus;

	// wired-and of both drivers
	assign bus = dev_tx & node_tx;

	modport dev (output dev_tx, input bus);
	modport node (output node_tx, input bus);
endinterface
`default_nettype wire

// File: cms_ctrl.sv
// cms_ctrl.sv - operating mode control and transmit scheduler of the controller
// assumes: one clock, synchronous bus input, software port with one-cycle strobes
// Contract
// - mode request 10:8, mode status 7:5
// - mode changes wait for 11 recessive bits
// - reset enters configuration mode, status 100
// - timing registers change only in configuration
// - request 000 gives normal transmit and receive
// - listen-only never drives ack or transmits
// - listen-all stores frames even with errors
// - loopback feeds transmit to receive, dummy ack
// - disable mode stops own bit clock
// - disable wakes on bus activity or write
// - disable holds transmit output recessive
// - bit 7 selects buffer for transmit
// - send request bit 3, cleared after sending
// - arbitrate pending buffers before start of frame
// - two-bit priority, 11 highest, 00 lowest
// - equal priority resolved by fixed natural order
// - software sets priority, writes message, then requests
// - transmitter until frame ends or arbitration lost
// - abort-all bit 12, abort only before start
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
module cms_ctrl (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// software register port
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// shared bus
	cms_link_if.dev link
);

	// ******************************
	// state
	// ******************************
	logic [2:0] mode_req_q, mode_stat_q;
	logic [7:0] cfg_a_q, cfg_b_q;
	logic [cms_pkg::NBUF-1:0] txsel_q, txreq_q;
	logic [1:0] pri_q [cms_pkg::NBUF];
	logic [cms_pkg::ID_W-1:0] id_q [cms_pkg::NBUF];
	logic [cms_pkg::DATA_W-1:0] data_q [cms_pkg::NBUF];
	logic abort_q, lost_q, rx_valid_q, rx_err_q, err_q, ack_ok_q, drv_q, tx_q, bus_prev_q;
	logic [8:0] cnt_q;
	logic [3:0] idle_q;
	logic [4:0] pos_q;
	logic [2:0] act_q;
	logic [27:0] sh_q;
	logic [18:0] rx_sh_q;
	logic [cms_pkg::ID_W-1:0] rx_id_q;
	logic [cms_pkg::DATA_W-1:0] rx_data_q;
	cms_pkg::cms_frame_type fr_q;

	// ******************************
	// decode
	// ******************************
	logic disabled, loopback, may_tx, may_ack, may_store, bus_in, bit_in;
	logic drive_pt, samp_pt, wr_ctrl, tx_done, end_pt, store_ok;
	logic mode_valid, win_ok;
	logic [2:0] win_idx;
	logic [1:0] win_pri;

	assign disabled = mode_stat_q == cms_pkg::MODE_DISABLE;
	assign loopback = mode_stat_q == cms_pkg::MODE_LOOPBACK;
	// only normal, listen-all and loopback transmit
	assign may_tx = (mode_stat_q == cms_pkg::MODE_NORMAL) || (mode_stat_q == cms_pkg::MODE_LISTEN_ALL) || loopback;
	assign may_ack = (mode_stat_q == cms_pkg::MODE_NORMAL) || (mode_stat_q == cms_pkg::MODE_LISTEN_ALL);
	assign may_store = may_tx || (mode_stat_q == cms_pkg::MODE_LISTEN_ONLY);
	// loopback turns the own drive bit back into the receive path
	assign bus_in = loopback ? drv_q : link.bus;
	assign bit_in = (loopback && pos_q == cms_pkg::POS_ACK) ? 1'b0 : bus_in;
	// no bit clock at all in disable mode
	assign drive_pt = !disabled && cnt_q == 9'h000;
	assign samp_pt = !disabled && cnt_q == {1'b0, cfg_a_q};
	assign wr_ctrl = reg_wr && reg_addr == cms_pkg::ADDR_CTRL1;
	assign end_pt = samp_pt && fr_q != cms_pkg::FR_IDLE && pos_q == cms_pkg::POS_LAST;
	assign tx_done = end_pt && fr_q == cms_pkg::FR_TX && ack_ok_q;
	assign store_ok = may_store && (fr_q == cms_pkg::FR_RX || loopback)
		&& (!(err_q || !bit_in) || mode_stat_q == cms_pkg::MODE_LISTEN_ALL);
	assign mode_valid = mode_req_q != 3'h5 && mode_req_q != 3'h6;

	// pick the pending buffer: priority first, higher index on ties
	always_comb begin
		win_ok = 1'b0;
		win_idx = 3'h0;
		win_pri = 2'h0;
		for (int i = 0; i < cms_pkg::NBUF; i++) begin
			if (txsel_q[i] && txreq_q[i] && (!win_ok || pri_q[i] >= win_pri)) begin
				win_ok = 1'b1;
				win_idx = 3'(i);
				win_pri = pri_q[i];
			end
		end
	end

	// ******************************
	// operating mode
	// ******************************
	// mode follows the request only after a long recessive run
	always_ff @(posedge clock) begin
		if (rst) begin
			mode_req_q <= cms_pkg::MODE_CONFIG;
			mode_stat_q <= cms_pkg::MODE_CONFIG;
		end else begin
			if (wr_ctrl)
				mode_req_q <= reg_wdata[cms_pkg::REQ_LO+:3];
			if (fr_q == cms_pkg::FR_IDLE && idle_q >= cms_pkg::IDLE_BITS && mode_valid && !disabled)
				mode_stat_q <= mode_req_q;
			if (!disabled && mode_stat_q != cms_pkg::MODE_DISABLE && mode_req_q == cms_pkg::MODE_DISABLE
				&& !(fr_q == cms_pkg::FR_IDLE && idle_q >= cms_pkg::IDLE_BITS))
				mode_stat_q <= mode_stat_q;
			if (disabled && (!link.bus || (wr_ctrl && reg_wdata[cms_pkg::STAT_LO+:3] == cms_pkg::MODE_NORMAL))) begin
				mode_stat_q <= cms_pkg::MODE_NORMAL;
				mode_req_q <= cms_pkg::MODE_NORMAL;
			end
		end
	end

	// ******************************
	// software writable registers
	// ******************************
	// timing words are locked outside configuration mode
	always_ff @(posedge clock) begin
		if (rst) begin
			cfg_a_q <= cms_pkg::CFG_A_RST;
			cfg_b_q <= cms_pkg::CFG_B_RST;
			txsel_q <= '0;
			for (int i = 0; i < cms_pkg::NBUF; i++) begin
				pri_q[i] <= 2'h0;
				id_q[i] <= '0;
				data_q[i] <= '0;
			end
		end else if (reg_wr) begin
			if (reg_addr == cms_pkg::ADDR_CFG_A && mode_stat_q == cms_pkg::MODE_CONFIG)
				cfg_a_q <= reg_wdata[7:0];
			if (reg_addr == cms_pkg::ADDR_CFG_B && mode_stat_q == cms_pkg::MODE_CONFIG)
				cfg_b_q <= reg_wdata[7:0];
			for (int i = 0; i < cms_pkg::NBUF; i++) begin
				if (reg_addr == cms_pkg::ADDR_PAIR0 + 5'(i / 2)) begin
					txsel_q[i] <= reg_wdata[(i % 2) * 8 + cms_pkg::BUF_TXSEL];
					pri_q[i] <= reg_wdata[(i % 2) * 8 + cms_pkg::BUF_PRI_LO+:2];
				end
				if (reg_addr == cms_pkg::ADDR_ID0 + 5'(i))
					id_q[i] <= reg_wdata[cms_pkg::ID_W-1:0];
				if (reg_addr == cms_pkg::ADDR_DATA0 + 5'(i))
					data_q[i] <= reg_wdata[cms_pkg::DATA_W-1:0];
			end
		end
	end

	// send requests: hardware clears after success, aborts spare the frame on the bus
	always_ff @(posedge clock) begin
		if (rst) begin
			txreq_q <= '0;
			abort_q <= 1'b0;
		end else begin
			if (wr_ctrl && reg_wdata[cms_pkg::CTRL_ABORT])
				abort_q <= 1'b1;
			else if (fr_q != cms_pkg::FR_TX)
				abort_q <= 1'b0;
			for (int i = 0; i < cms_pkg::NBUF; i++) begin
				if (tx_done && act_q == 3'(i))
					txreq_q[i] <= 1'b0;
				if (abort_q && !(fr_q == cms_pkg::FR_TX && act_q == 3'(i)))
					txreq_q[i] <= 1'b0;
				if (reg_wr && reg_addr == cms_pkg::ADDR_PAIR0 + 5'(i / 2)
					&& !(fr_q == cms_pkg::FR_TX && act_q == 3'(i)))
					txreq_q[i] <= reg_wdata[(i % 2) * 8 + cms_pkg::BUF_TXREQ];
			end
		end
	end

	// ******************************
	// bit timer
	// ******************************
	// restarts on a falling edge seen while idle
	always_ff @(posedge clock) begin
		if (rst) begin
			cnt_q <= 9'h000;
			bus_prev_q <= 1'b1;
		end else if (!disabled) begin
			bus_prev_q <= bus_in;
			if (fr_q == cms_pkg::FR_IDLE && bus_prev_q && !bus_in && !drive_pt)
				cnt_q <= 9'h001;
			else if (cnt_q == {1'b0, cfg_a_q} + {1'b0, cfg_b_q} + 9'h001)
				cnt_q <= 9'h000;
			else
				cnt_q <= cnt_q + 9'h001;
		end
	end

	// ******************************
	// frame engine
	// ******************************
	always_ff @(posedge clock) begin
		if (rst) begin
			fr_q <= cms_pkg::FR_IDLE;
			pos_q <= 5'h00;
			sh_q <= '1;
			act_q <= 3'h0;
			drv_q <= 1'b1;
			tx_q <= 1'b1;
			idle_q <= 4'h0;
			ack_ok_q <= 1'b0;
			err_q <= 1'b0;
			rx_sh_q <= '0;
		end else begin
			if (drive_pt) begin
				if (fr_q == cms_pkg::FR_IDLE) begin
					if (may_tx && win_ok && !abort_q && idle_q >= cms_pkg::IFS_BITS) begin
						fr_q <= cms_pkg::FR_TX;
						pos_q <= 5'h00;
						act_q <= win_idx;
						sh_q <= {1'b0, id_q[win_idx], data_q[win_idx], 1'b1, cms_pkg::EOF_FIELD};
						drv_q <= 1'b0;
					end else
						drv_q <= 1'b1;
				end else if (pos_q == cms_pkg::POS_LAST) begin
					fr_q <= cms_pkg::FR_IDLE;
					drv_q <= 1'b1;
				end else begin
					pos_q <= pos_q + 5'h01;
					sh_q <= {sh_q[26:0], 1'b1};
					if (fr_q == cms_pkg::FR_TX)
						drv_q <= sh_q[26];
					else
						drv_q <= !(pos_q + 5'h01 == cms_pkg::POS_ACK && may_ack);
				end
			end
			if (samp_pt) begin
				if (fr_q == cms_pkg::FR_IDLE) begin
					ack_ok_q <= 1'b0;
					err_q <= 1'b0;
					if (bit_in) begin
						if (idle_q < cms_pkg::IDLE_BITS)
							idle_q <= idle_q + 4'h1;
					end else begin
						idle_q <= 4'h0;
						fr_q <= cms_pkg::FR_RX;
						pos_q <= 5'h00;
					end
				end else begin
					idle_q <= 4'h0;
					if (pos_q >= cms_pkg::POS_ID_FIRST && pos_q <= cms_pkg::POS_DATA_LAST)
						rx_sh_q <= {rx_sh_q[17:0], bit_in};
					// lost arbitration: keep listening, request stays pending
					if (fr_q == cms_pkg::FR_TX && pos_q >= cms_pkg::POS_ID_FIRST && pos_q <= cms_pkg::POS_ID_LAST
						&& drv_q && !bit_in)
						fr_q <= cms_pkg::FR_RX;
					if (fr_q == cms_pkg::FR_TX && pos_q == cms_pkg::POS_ACK)
						ack_ok_q <= !bit_in;
					if (pos_q >= cms_pkg::POS_EOF_FIRST && !bit_in)
						err_q <= 1'b1;
				end
			end
			// outside pin recessive in loopback and disable
			tx_q <= (loopback || disabled) ? 1'b1 : drv_q;
		end
	end

	// ******************************
	// receive result and status
	// ******************************
	always_ff @(posedge clock) begin
		if (rst) begin
			rx_valid_q <= 1'b0;
			rx_err_q <= 1'b0;
			lost_q <= 1'b0;
			rx_id_q <= '0;
			rx_data_q <= '0;
		end else begin
			if (reg_rd && reg_addr == cms_pkg::ADDR_RX_DATA)
				rx_valid_q <= 1'b0;
			if (reg_rd && reg_addr == cms_pkg::ADDR_STATUS)
				lost_q <= 1'b0;
			if (samp_pt && fr_q == cms_pkg::FR_TX && pos_q <= cms_pkg::POS_ID_LAST && drv_q && !bit_in)
				lost_q <= 1'b1;
			if (end_pt && store_ok) begin
				rx_valid_q <= 1'b1;
				rx_err_q <= err_q || !bit_in;
				rx_id_q <= rx_sh_q[18:8];
				rx_data_q <= rx_sh_q[7:0];
			end
		end
	end

	// read data stands one cycle after the strobe
	always_ff @(posedge clock) begin
		if (rst)
			reg_rdata <= 16'h0000;
		else if (reg_rd) begin
			reg_rdata <= 16'h0000;
			if (reg_addr == cms_pkg::ADDR_CTRL1)
				reg_rdata <= {3'h0, abort_q, 1'b0, mode_req_q, mode_stat_q, 5'h00};
			if (reg_addr == cms_pkg::ADDR_CFG_A)
				reg_rdata <= {8'h00, cfg_a_q};
			if (reg_addr == cms_pkg::ADDR_CFG_B)
				reg_rdata <= {8'h00, cfg_b_q};
			if (reg_addr == cms_pkg::ADDR_STATUS)
				reg_rdata <= {12'h000, lost_q, fr_q == cms_pkg::FR_TX, rx_err_q, rx_valid_q};
			if (reg_addr == cms_pkg::ADDR_RX_ID)
				reg_rdata <= {5'h00, rx_id_q};
			if (reg_addr == cms_pkg::ADDR_RX_DATA)
				reg_rdata <= {8'h00, rx_data_q};
			for (int i = 0; i < cms_pkg::NBUF; i++) begin
				if (reg_addr == cms_pkg::ADDR_PAIR0 + 5'(i / 2))
					reg_rdata[(i % 2) * 8+:8] <= {txsel_q[i], 3'h0, txreq_q[i], 1'b0, pri_q[i]};
				if (reg_addr == cms_pkg::ADDR_ID0 + 5'(i))
					reg_rdata <= {5'h00, id_q[i]};
				if (reg_addr == cms_pkg::ADDR_DATA0 + 5'(i))
					reg_rdata <= {8'h00, data_q[i]};
			end
		end
	end

	assign link.dev_tx = tx_q;

endmodule
`default_nettype wire

// File: cms_node.sv
// cms_node.sv - a plain remote node on the shared bus: sends, receives, acknowledges
// assumes: same bit timing as the controller, synchronous bus input
`timescale 1ns/10ps
`default_nettype none
module cms_node (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// bit timing
	input wire logic [7:0] bit_seg_a,
	input wire logic [7:0] bit_seg_b,
	// send request
	input wire logic send_req,
	input wire logic [10:0] send_id,
	input wire logic [7:0] send_data,
	input wire logic ack_enable,
	output logic send_busy,
	output logic send_done,
	output logic send_lost,
	// receive report
	output logic rx_valid,
	output logic [10:0] rx_id,
	output logic [7:0] rx_data,
	output logic rx_err,
	// shared bus
	cms_link_if.node link
);

	// ******************************
	// state
	// ******************************
	logic [8:0] cnt_q;
	logic [3:0] idle_q;
	logic [4:0] pos_q;
	logic [27:0] sh_q, pend_q;
	logic [18:0] rx_sh_q;
	logic drv_q, bus_prev_q, ack_ok_q, err_q;
	cms_pkg::cms_frame_type fr_q;
	logic drive_pt, samp_pt, end_pt;

	assign drive_pt = cnt_q == 9'h000;
	assign samp_pt = cnt_q == {1'b0, bit_seg_a};
	assign end_pt = samp_pt && fr_q != cms_pkg::FR_IDLE && pos_q == cms_pkg::POS_LAST;

	// bit timer with hard sync on an idle falling edge
	always_ff @(posedge clock) begin
		if (rst) begin
			cnt_q <= 9'h000;
			bus_prev_q <= 1'b1;
		end else begin
			bus_prev_q <= link.bus;
			if (fr_q == cms_pkg::FR_IDLE && bus_prev_q && !link.bus && !drive_pt)
				cnt_q <= 9'h001;
			else if (cnt_q == {1'b0, bit_seg_a} + {1'b0, bit_seg_b} + 9'h001)
				cnt_q <= 9'h000;
			else
				cnt_q <= cnt_q + 9'h001;
		end
	end

	// ******************************
	// frame engine
	// ******************************
	always_ff @(posedge clock) begin
		if (rst) begin
			fr_q <= cms_pkg::FR_IDLE;
			pos_q <= 5'h00;
			sh_q <= '1;
			pend_q <= '1;
			send_busy <= 1'b0;
			drv_q <= 1'b1;
			idle_q <= 4'h0;
			ack_ok_q <= 1'b0;
			err_q <= 1'b0;
			rx_sh_q <= '0;
		end else begin
			// one pending frame, kept until acknowledged
			if (send_req && !send_busy) begin
				send_busy <= 1'b1;
				pend_q <= {1'b0, send_id, send_data, 1'b1, cms_pkg::EOF_FIELD};
			end
			if (end_pt && fr_q == cms_pkg::FR_TX && ack_ok_q)
				send_busy <= 1'b0;
			if (drive_pt) begin
				if (fr_q == cms_pkg::FR_IDLE) begin
					if (send_busy && idle_q >= cms_pkg::IFS_BITS) begin
						fr_q <= cms_pkg::FR_TX;
						pos_q <= 5'h00;
						sh_q <= pend_q;
						drv_q <= 1'b0;
					end else
						drv_q <= 1'b1;
				end else if (pos_q == cms_pkg::POS_LAST) begin
					fr_q <= cms_pkg::FR_IDLE;
					drv_q <= 1'b1;
				end else begin
					pos_q <= pos_q + 5'h01;
					sh_q <= {sh_q[26:0], 1'b1};
					if (fr_q == cms_pkg::FR_TX)
						drv_q <= sh_q[26];
					else
						drv_q <= !(pos_q + 5'h01 == cms_pkg::POS_ACK && ack_enable);
				end
			end
			if (samp_pt) begin
				if (fr_q == cms_pkg::FR_IDLE) begin
					ack_ok_q <= 1'b0;
					err_q <= 1'b0;
					if (link.bus) begin
						if (idle_q < cms_pkg::IDLE_BITS)
							idle_q <= idle_q + 4'h1;
					end else begin
						idle_q <= 4'h0;
						fr_q <= cms_pkg::FR_RX;
						pos_q <= 5'h00;
					end
				end else begin
					idle_q <= 4'h0;
					if (pos_q >= cms_pkg::POS_ID_FIRST && pos_q <= cms_pkg::POS_DATA_LAST)
						rx_sh_q <= {rx_sh_q[17:0], link.bus};
					if (fr_q == cms_pkg::FR_TX && pos_q >= cms_pkg::POS_ID_FIRST && pos_q <= cms_pkg::POS_ID_LAST
						&& drv_q && !link.bus)
						fr_q <= cms_pkg::FR_RX;
					if (fr_q == cms_pkg::FR_TX && pos_q == cms_pkg::POS_ACK)
						ack_ok_q <= !link.bus;
					if (pos_q >= cms_pkg::POS_EOF_FIRST && !link.bus)
						err_q <= 1'b1;
				end
			end
		end
	end

	// ******************************
	// user side pulses and receive report
	// ******************************
	always_ff @(posedge clock) begin
		if (rst) begin
			send_done <= 1'b0;
			send_lost <= 1'b0;
			rx_valid <= 1'b0;
			rx_id <= '0;
			rx_data <= '0;
			rx_err <= 1'b0;
		end else begin
			send_done <= end_pt && fr_q == cms_pkg::FR_TX && ack_ok_q;
			send_lost <= samp_pt && fr_q == cms_pkg::FR_TX && pos_q <= cms_pkg::POS_ID_LAST && drv_q && !link.bus;
			rx_valid <= end_pt && fr_q == cms_pkg::FR_RX;
			if (end_pt && fr_q == cms_pkg::FR_RX) begin
				rx_id <= rx_sh_q[18:8];
				rx_data <= rx_sh_q[7:0];
				rx_err <= err_q || !link.bus;
			end
		end
	end

	assign link.node_tx = drv_q;

endmodule
`default_nettype wire

// File: cms_link_asserts.sv
// cms_link_asserts.sv - wire checks on the shared bus between controller and node
// assumes: both ends keep the reset bit timing of 8 clocks a bit
`timescale 1ns/10ps
`default_nettype none
module cms_link_asserts (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// bus wire
	input wire logic dev_tx,
	input wire logic node_tx,
	input wire logic bus
);
	// ****************
	// helper counters
	// ****************
	localparam int GAP_MIN = 72;
	logic [7:0] rec_q;
	logic [7:0] frm_q;
	logic [7:0] run_q;
	logic sof;
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (rst);
	// a dominant edge outside any frame window starts a frame
	assign sof = !bus && rec_q != 8'h00 && frm_q == 8'h00;
	// recessive run length, frame window, cycles since reset
	always_ff @(posedge clock) begin
		if (rst) begin
			rec_q <= 8'hff;
			frm_q <= 8'h00;
			run_q <= 8'h00;
		end else begin
			rec_q <= !bus ? 8'h00 : rec_q + {7'h00, rec_q != 8'hff};
			frm_q <= sof ? 8'hc8 : frm_q - {7'h00, frm_q != 8'h00};
			run_q <= run_q + {7'h00, run_q != 8'hff};
		end
	end
	// ****************
	// assertions
	// ****************
	a_reset_recessive: assert property ($fell(rst) |-> (dev_tx && node_tx)[*8])
		else $error("bus driven right after reset");
	a_bus_wired: assert property (bus == (dev_tx & node_tx))
		else $error("bus is not the and of both drivers");
	a_dev_bit_hold: assert property ($changed(dev_tx) |=> $stable(dev_tx)[*7])
		else $error("controller bit shorter than one period");
	a_node_bit_hold: assert property ($changed(node_tx) |=> $stable(node_tx)[*7])
		else $error("node bit shorter than one period");
	a_sof_gap: assert property (sof |-> rec_q >= GAP_MIN)
		else $error("frame started without interframe gap");
	a_sof_dominant: assert property (sof |-> (!bus)[*8])
		else $error("start bit not one period dominant");
	// receivers lag the transmitter by up to two cycles, so their ack may reach into the first end bit
	a_eof_recessive: assert property (sof |-> ##176 bus[*8])
		else $error("end of frame not recessive");
	a_late_first_tx: assert property ($fell(dev_tx) |-> run_q >= 8'h58)
		else $error("controller drove bus before leaving configuration");
	// main traffic seen on the wire
	c_dev_sof: cover property (sof && !dev_tx);
	c_node_sof: cover property (sof && !node_tx);
	c_node_dominant: cover property (dev_tx && !node_tx && frm_q != 8'h00);
endmodule
`default_nettype wire

// File: tb_top.sv
// tb_top.sv - controller and node joined on one bus, driven through registers and node ports
// assumes: both ends on reset bit timing, checker watches the bus wire
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clock;
	logic rst;
	logic [4:0] reg_addr;
	logic [15:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [15:0] reg_rdata;
	logic send_req;
	logic [10:0] send_id;
	logic [7:0] send_data;
	logic ack_enable;
	logic send_busy;
	logic send_done;
	logic rx_valid;
	logic [10:0] rx_id;
	logic [7:0] rx_data;
	int mismatches;
	int n_compared;
	int n_done;
	int dev_low;
	int k, p, n0, l0;
	logic [31:0] rs;
	logic [15:0] d;
	logic [18:0] got_q[$];
	logic [18:0] exp_q[$];
	logic [1:0] pri[8];
	logic [10:0] bid[8];
	logic [7:0] bdat[8];
	cms_link_if link();
	cms_ctrl cms_ctrl_inst(.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link.dev));
	cms_node cms_node_inst(.clock(clock), .rst(rst), .bit_seg_a(8'h03), .bit_seg_b(8'h03),
		.send_req(send_req), .send_id(send_id), .send_data(send_data), .ack_enable(ack_enable),
		.send_busy(send_busy), .send_done(send_done), .send_lost(), .rx_valid(rx_valid),
		.rx_id(rx_id), .rx_data(rx_data), .rx_err(), .link(link.node));
	cms_link_asserts cms_link_asserts_inst(.clock(clock), .rst(rst), .dev_tx(link.dev_tx),
		.node_tx(link.node_tx), .bus(link.bus));
	// ****************
	// clock, monitors, tasks
	// ****************
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// frames seen by the node, acknowledged node sends, controller dominant cycles
	always @(posedge clock) begin
		if (rx_valid === 1'b1) got_q.push_back({rx_id, rx_data});
		if (send_done === 1'b1) n_done++;
		if (link.dev_tx !== 1'b1) dev_low++;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// pair register value: select set, request r, random priorities
	function automatic logic [15:0] pv(input int j, input logic r);
		return {1'b1, 3'h0, r, 1'b0, pri[2*j+1], 1'b1, 3'h0, r, 1'b0, pri[2*j]};
	endfunction
	task automatic chk(input string nm, input logic [18:0] e, input logic [18:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic waitn(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	// plain read, data taken in the cycle after the strobe
	task automatic rd(input logic [4:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic rdchk(input string nm, input logic [4:0] a, input logic [15:0] e);
		rd(a);
		chk(nm, {3'h0, e}, {3'h0, d});
	endtask
	// request a mode, poll status until it shows or time runs out
	task automatic mode(input logic [2:0] m, input logic [2:0] e);
		int i;
		wr(5'h00, {5'h00, m, 8'h00});
		rd(5'h00);
		for (i = 0; i < 300 && d[7:5] !== m; i++)
			rd(5'h00);
		chk("mode status", {16'h0000, e}, {16'h0000, d[7:5]});
	endtask
	task automatic nsend(input logic [10:0] i, input logic [7:0] v);
		@(posedge clock);
		send_req <= 1'b1;
		send_id <= i;
		send_data <= v;
		@(posedge clock);
		send_req <= 1'b0;
	endtask
	task summarize;
		$display("mismatches %0d compared %0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// watchdog cuts a hang short
	initial begin
		#240000;
		mismatches++;
		summarize();
	end
	// ****************
	// main sequence
	// ****************
	initial begin
		rst = 1'b1;
		{reg_addr, reg_wdata, reg_wr, reg_rd, send_req, send_id, send_data} = '0;
		ack_enable = 1'b1;
		d = 16'h0000;
		rs = 32'hbf1e;
		waitn(16);
		rst <= 1'b0;
		rdchk("ctrl1 reset", 5'h00, 16'h0480);
		rdchk("cfg a reset", 5'h01, 16'h0003);
		rdchk("unmapped", 5'h1f, 16'h0000);
		wr(5'h02, 16'h0005);
		rdchk("cfg b in config", 5'h02, 16'h0005);
		wr(5'h02, 16'h0003);
		// eight buffers: select and priority, message, then request
		for (k = 0; k < 8; k++) begin
			rs = lfsr(rs);
			{bdat[k], bid[k], pri[k]} = rs[20:0];
		end
		for (k = 0; k < 4; k++)
			wr(5'h04 + 5'(k), pv(k, 1'b0));
		for (k = 0; k < 8; k++) begin
			wr(5'h08 + 5'(k), {5'h00, bid[k]});
			wr(5'h10 + 5'(k), {8'h00, bdat[k]});
		end
		for (k = 0; k < 4; k++)
			wr(5'h04 + 5'(k), pv(k, 1'b1));
		rdchk("pair readback", 5'h07, pv(3, 1'b1));
		for (p = 3; p >= 0; p--)
			for (k = 7; k >= 0; k--)
				if (pri[k] == p[1:0])
					exp_q.push_back({bid[k], bdat[k]});
		wr(5'h00, 16'h0000);
		rdchk("mode held", 5'h00, 16'h0080);
		waitn(4);
		rdchk("mode still held", 5'h00, 16'h0080);
		mode(3'h0, 3'h0);
		for (k = 0; k < 4000 && got_q.size() < 8; k++)
			@(posedge clock);
		for (k = 0; k < 8; k++)
			chk("frame order", exp_q[k], got_q[k]);
		for (k = 0; k < 4; k++)
			rdchk("request cleared", 5'h04 + 5'(k), pv(k, 1'b0));
		wr(5'h01, 16'h0009);
		rdchk("cfg a locked", 5'h01, 16'h0003);
		// node to controller
		rs = lfsr(rs);
		n0 = n_done;
		nsend(rs[10:0], rs[18:11]);
		for (k = 0; k < 600 && n_done == n0; k++)
			@(posedge clock);
		chk("node acked", 19'(n0 + 1), 19'(n_done));
		rdchk("rx id", 5'h18, {5'h00, rs[10:0]});
		rdchk("rx data", 5'h19, {8'h00, rs[18:11]});
		mode(3'h7, 3'h7);
		mode(3'h5, 3'h7);
		mode(3'h2, 3'h2);
		// loopback: buffer 5 goes round internally, bus stays quiet
		n0 = got_q.size();
		l0 = dev_low;
		wr(5'h06, 16'h8300);
		wr(5'h06, 16'h8b00);
		waitn(500);
		rdchk("loopback request", 5'h06, 16'h8300);
		rdchk("loopback rx id", 5'h18, {5'h00, bid[5]});
		rdchk("loopback status", 5'h03, 16'h0001);
		chk("loopback quiet", 19'(l0 + n0), 19'(dev_low + got_q.size()));
		// abort all while the first frame is on the bus
		mode(3'h4, 3'h4);
		wr(5'h04, 16'h8382);
		wr(5'h04, 16'h8b8a);
		wr(5'h05, 16'h0081);
		wr(5'h05, 16'h0089);
		mode(3'h0, 3'h0);
		n0 = got_q.size();
		for (k = 0; k < 600 && link.dev_tx !== 1'b0; k++)
			@(posedge clock);
		wr(5'h00, 16'h1000);
		waitn(700);
		chk("abort frames", 19'(n0 + 1), 19'(got_q.size()));
		rdchk("abort pair0", 5'h04, 16'h8382);
		rdchk("abort pair1", 5'h05, 16'h0081);
		// disable holds a pending request until a wake write
		mode(3'h1, 3'h1);
		n0 = got_q.size();
		l0 = dev_low;
		wr(5'h04, 16'h0083);
		wr(5'h04, 16'h008b);
		waitn(300);
		chk("disable quiet", 19'(l0), 19'(dev_low));
		wr(5'h00, 16'h0000);
		rdchk("wake by write", 5'h00, 16'h0000);
		for (k = 0; k < 800 && got_q.size() == n0; k++)
			@(posedge clock);
		chk("send after wake", 19'(n0 + 1), 19'(got_q.size()));
		// listen-only never acknowledges but still stores
		mode(3'h3, 3'h3);
		n0 = n_done;
		nsend(11'h5a5, 8'h3c);
		waitn(800);
		#1;
		chk("listen only ack", 19'(n0), 19'(n_done));
		chk("node retrying", 19'h00001, {18'h00000, send_busy});
		rdchk("listen only rx", 5'h18, 16'h05a5);
		@(posedge clock);
		rst <= 1'b1;
		waitn(16);
		rst <= 1'b0;
		rdchk("ctrl1 second reset", 5'h00, 16'h0480);
		summarize();
	end
endmodule
`default_nettype wire
